// ---- difl_pkg.sv ----
`default_nettype none
package difl_pkg;
  localparam int unsigned NUM_TERM = 8;
  localparam int unsigned FW       = 16;

  // Terminal function codes
  localparam logic [7:0] FC_KEYPAD_FORCE = 8'h1F;
  localparam logic [7:0] FC_TERM_FORCE   = 8'h33;
  localparam logic [7:0] FC_P_PI         = 8'h2B;
  localparam logic [7:0] FC_ANALOG_HOLD  = 8'h41;
  localparam logic [7:0] FC_PULSE_CNT    = 8'h4A;
  localparam logic [7:0] FC_PULSE_CLR    = 8'h4B;
  localparam logic [7:0] FC_SPEED_UP     = 8'h1B;
  localparam logic [7:0] FC_SPEED_DOWN   = 8'h1C;

  localparam logic [7:0] CM_SENSORLESS_VECTOR      = 8'h03;
  localparam logic [7:0] CM_ZERO_SPEED_SENSORLESS  = 8'h04;
  localparam logic [7:0] CM_SENSOR_VECTOR          = 8'h05;

  localparam logic [7:0] SRC_TERMINAL = 8'h01;
  localparam logic [7:0] SRC_KEYPAD   = 8'h02;
  localparam logic [7:0] STORE_KEEP   = 8'h01;

  // Gain in hundredths
  localparam logic [FW-1:0] P_GAIN_MIN = 16'h0001;
  localparam logic [FW-1:0] P_GAIN_MAX = 16'h03E8;
  localparam logic [FW-1:0] FREQ_MAX   = 16'hFFFF;
  localparam logic [FW-1:0] FREQ_RST   = 16'h0000;

  localparam int unsigned CLK_PERIOD_NS = 4;
  // One response-time step is half the period of a 250 Hz pulse train
  localparam int unsigned RESP_UNIT_NS  = 2000000;
  localparam int unsigned RESP_UNIT_CYC = RESP_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned UPDN_STEP_NS  = 1000000;
  localparam int unsigned UPDN_STEP_CYC = UPDN_STEP_NS / CLK_PERIOD_NS;

  typedef enum logic [0:0] {
    RB_FREE   = 1'b0,
    RB_LOCKED = 1'b1
  } difl_rb_t;

  typedef struct packed {
    logic [7:0] freq_source_select;
    logic [7:0] run_source_select;
    logic [7:0] control_method_select;
    logic [7:0] updown_store_select;
  } difl_cfg_t;

  typedef struct packed {
    logic run_terminal;
    logic run_keypad;
    logic run_aux;
  } difl_run_t;
endpackage
`default_nettype wire

// ---- difl_in_filter.sv ----
`timescale 1ns/10ps
`default_nettype none
module difl_in_filter #(
  parameter int unsigned UNIT_CYC = 500000
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_ce,
  input  wire logic       i_raw,
  input  wire logic [7:0] i_resp,
  output logic            o_lvl
);
  logic [31:0] unit_r;
  logic [8:0]  step_r;

  // A level must hold (resp+1) whole steps before it is taken
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      unit_r <= 32'h0;
      step_r <= 9'h000;
      o_lvl  <= 1'b0;
    end else if (i_ce) begin
      if (i_raw == o_lvl) begin
        unit_r <= 32'h0;
        step_r <= 9'h000;
      end else if (unit_r == 32'(UNIT_CYC - 1)) begin
        unit_r <= 32'h0;
        if (step_r == {1'b0, i_resp}) begin
          o_lvl  <= i_raw;
          step_r <= 9'h000;
        end else begin
          step_r <= step_r + 9'h001;
        end
      end else begin
        unit_r <= unit_r + 32'h1;
      end
    end
  end

  a_filter_settle: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(o_lvl) |-> $past(i_raw) == o_lvl && $past(i_ce))
    else $error("filtered level changed without a stable raw input");
endmodule
`default_nettype wire

// ---- difl_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module difl_top #(
  parameter int unsigned RESP_UNIT_CYC = difl_pkg::RESP_UNIT_CYC,
  parameter int unsigned UPDN_STEP_CYC = difl_pkg::UPDN_STEP_CYC,
  parameter int unsigned CNT_W         = 32
) (
  input  wire logic                                    I_CORE_CLK,
  input  wire logic                                    I_RST,
  input  wire logic                                    I_CE,
  input  wire logic [difl_pkg::NUM_TERM-1:0]           I_TERM,
  input  wire logic [difl_pkg::NUM_TERM-1:0][7:0]      I_INPUT_FUNCTION_SELECT,
  input  wire logic [difl_pkg::NUM_TERM-1:0][7:0]      I_INPUT_RESPONSE_TIME,
  input  wire difl_pkg::difl_cfg_t                     I_CFG,
  input  wire difl_pkg::difl_run_t                     I_RUN_REQ,
  input  wire logic [difl_pkg::FW-1:0]                 I_FREQ_ANALOG,
  input  wire logic [difl_pkg::FW-1:0]                 I_KEYPAD_FREQ_SETTING,
  input  wire logic [difl_pkg::FW-1:0]                 I_FREQ_AUX,
  input  wire logic [difl_pkg::FW-1:0]                 I_P_ONLY_GAIN,
  input  wire logic [difl_pkg::FW-1:0]                 I_PI_GAIN,
  input  wire logic                                    I_DRIVE_RESET_INPUT,
  input  wire logic [1:0]                              I_CONTROL_SET_SELECT,
  input  wire logic [difl_pkg::FW-1:0]                 I_NV_HOLD_DATA,
  output logic                                         O_RUN,
  output logic [difl_pkg::FW-1:0]                      O_FREQ_REF,
  output logic [7:0]                                   O_FREQ_SRC,
  output logic [7:0]                                   O_RUN_SRC,
  output logic                                         O_P_ONLY,
  output logic [difl_pkg::FW-1:0]                      O_P_GAIN_VALUE,
  output logic [CNT_W-1:0]                             O_PULSE_TOTAL_MONITOR,
  output logic [difl_pkg::FW-1:0]                      O_NV_HOLD_DATA,
  output logic                                         O_NV_HOLD_WE
);
  import difl_pkg::*;

  logic [NUM_TERM-1:0] lvl;
  logic [NUM_TERM-1:0] kf_v;
  logic [NUM_TERM-1:0] tf_v;
  logic [NUM_TERM-1:0] ppi_v;
  logic [NUM_TERM-1:0] ahd_v;
  logic [NUM_TERM-1:0] pc_v;
  logic [NUM_TERM-1:0] pcc_v;
  logic [NUM_TERM-1:0] up_v;
  logic [NUM_TERM-1:0] dn_v;
  logic                keypad_force;
  logic                terminal_force;
  logic                p_pi_select;
  logic                analog_hold;
  logic                pulse_count_input;
  logic                pulse_count_clear;
  logic                speed_up;
  logic                speed_decrease_input;
  logic [7:0]          fsrc;
  logic [7:0]          rsrc;
  logic                run_sel;
  logic [FW-1:0]       freq_nxt;
  logic [1:0]          force_prev_r;
  logic                force_flip;
  logic                any_req;
  difl_rb_t            rb_r;
  difl_rb_t            rb_nxt;
  logic                method_ok;
  logic                p_only_nxt;
  logic [FW-1:0]       p_gain_clamped;
  logic                ahd_prev_r;
  logic                pc_prev_r;
  logic                drs_prev_r;
  logic                drs_fall;
  logic                boot_r;
  logic [31:0]         step_r;
  logic                tick;
  logic [FW-1:0]       base_r;
  logic [FW-1:0]       hold_val_r;
  logic [FW-1:0]       nv_nxt;

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_RST);

  //////////////////////////////////////////////////////////////////////////////
  // Terminal filtering and function decode

  for (genvar g = 0; g < NUM_TERM; g++) begin : g_term
    difl_in_filter #(
      .UNIT_CYC (RESP_UNIT_CYC)
    ) u_flt (
      .i_clk  (I_CORE_CLK),
      .i_rst  (I_RST),
      .i_ce   (I_CE),
      .i_raw  (I_TERM[g]),
      .i_resp (I_INPUT_RESPONSE_TIME[g]),
      .o_lvl  (lvl[g])
    );
    assign kf_v[g]  = lvl[g] && (I_INPUT_FUNCTION_SELECT[g] == FC_KEYPAD_FORCE);
    assign tf_v[g]  = lvl[g] && (I_INPUT_FUNCTION_SELECT[g] == FC_TERM_FORCE);
    assign ppi_v[g] = lvl[g] && (I_INPUT_FUNCTION_SELECT[g] == FC_P_PI);
    assign ahd_v[g] = lvl[g] && (I_INPUT_FUNCTION_SELECT[g] == FC_ANALOG_HOLD);
    assign pc_v[g]  = lvl[g] && (I_INPUT_FUNCTION_SELECT[g] == FC_PULSE_CNT);
    assign pcc_v[g] = lvl[g] && (I_INPUT_FUNCTION_SELECT[g] == FC_PULSE_CLR);
    assign up_v[g]  = lvl[g] && (I_INPUT_FUNCTION_SELECT[g] == FC_SPEED_UP);
    assign dn_v[g]  = lvl[g] && (I_INPUT_FUNCTION_SELECT[g] == FC_SPEED_DOWN);
  end

  // An unassigned function has an all-zero vector and stays off
  assign keypad_force         = |kf_v;
  assign terminal_force       = |tf_v;
  assign p_pi_select          = |ppi_v;
  assign analog_hold          = |ahd_v;
  assign pulse_count_input    = |pc_v;
  assign pulse_count_clear    = |pcc_v;
  assign speed_up             = |up_v;
  assign speed_decrease_input = |dn_v;

  //////////////////////////////////////////////////////////////////////////////
  // Command source selection

  // Keypad force outranks terminal force when both are on
  always_comb begin
    fsrc = I_CFG.freq_source_select;
    rsrc = I_CFG.run_source_select;
    if (keypad_force) begin
      fsrc = SRC_KEYPAD;
      rsrc = SRC_KEYPAD;
    end else if (terminal_force) begin
      fsrc = SRC_TERMINAL;
      rsrc = SRC_TERMINAL;
    end
  end

  always_comb begin
    case (rsrc)
      SRC_TERMINAL: run_sel = I_RUN_REQ.run_terminal;
      SRC_KEYPAD:   run_sel = I_RUN_REQ.run_keypad;
      default:      run_sel = I_RUN_REQ.run_aux;
    endcase
  end

  always_comb begin
    case (fsrc)
      SRC_TERMINAL: freq_nxt = (analog_hold && ahd_prev_r) ? hold_val_r : I_FREQ_ANALOG;
      SRC_KEYPAD:   freq_nxt = I_KEYPAD_FREQ_SETTING;
      default:      freq_nxt = I_FREQ_AUX;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Run lockout after a forced-source change

  assign force_flip = ({keypad_force, terminal_force} != force_prev_r);
  assign any_req    = |I_RUN_REQ;

  // The lock is released only once every source has dropped its run request
  always_comb begin
    case (rb_r)
      RB_FREE:   rb_nxt = (force_flip && O_RUN) ? RB_LOCKED : RB_FREE;
      RB_LOCKED: rb_nxt = (any_req || (force_flip && O_RUN)) ? RB_LOCKED : RB_FREE;
      default:   rb_nxt = RB_FREE;
    endcase
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      force_prev_r <= 2'h0;
      rb_r         <= RB_FREE;
      O_RUN        <= 1'b0;
      O_FREQ_REF   <= FREQ_RST;
      O_FREQ_SRC   <= 8'h00;
      O_RUN_SRC    <= 8'h00;
    end else if (I_CE) begin
      force_prev_r <= {keypad_force, terminal_force};
      rb_r         <= rb_nxt;
      O_RUN        <= run_sel && (rb_nxt == RB_FREE);
      O_FREQ_REF   <= freq_nxt;
      O_FREQ_SRC   <= fsrc;
      O_RUN_SRC    <= rsrc;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Speed loop P/PI selection

  assign method_ok = (I_CFG.control_method_select == CM_SENSORLESS_VECTOR) ||
                     (I_CFG.control_method_select == CM_ZERO_SPEED_SENSORLESS) ||
                     (I_CFG.control_method_select == CM_SENSOR_VECTOR);
  assign p_only_nxt = p_pi_select && method_ok;
  // Out-of-range gain settings are pinned to the legal span
  assign p_gain_clamped = (I_P_ONLY_GAIN < P_GAIN_MIN) ? P_GAIN_MIN :
                          (I_P_ONLY_GAIN > P_GAIN_MAX) ? P_GAIN_MAX : I_P_ONLY_GAIN;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_P_ONLY       <= 1'b0;
      O_P_GAIN_VALUE <= FREQ_RST;
    end else if (I_CE) begin
      O_P_ONLY       <= p_only_nxt;
      O_P_GAIN_VALUE <= p_only_nxt ? p_gain_clamped : I_PI_GAIN;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Analog hold with up/down adjustment

  assign drs_fall = drs_prev_r && !I_DRIVE_RESET_INPUT;
  assign tick     = (step_r == 32'(UPDN_STEP_CYC - 1));

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      step_r <= 32'h0;
    end else if (I_CE) begin
      step_r <= tick ? 32'h0 : step_r + 32'h1;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      boot_r     <= 1'b1;
      ahd_prev_r <= 1'b0;
      drs_prev_r <= 1'b0;
    end else if (I_CE) begin
      boot_r     <= 1'b0;
      ahd_prev_r <= analog_hold;
      drs_prev_r <= I_DRIVE_RESET_INPUT;
    end
  end

  // Only a fresh hold edge samples the analog input, so a control set
  // switch during hold leaves the set frequency untouched
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      base_r     <= FREQ_RST;
      hold_val_r <= FREQ_RST;
    end else if (I_CE) begin
      if (boot_r || drs_fall) begin
        base_r     <= I_NV_HOLD_DATA;
        hold_val_r <= I_NV_HOLD_DATA;
      end else if (analog_hold && !ahd_prev_r) begin
        base_r     <= I_FREQ_ANALOG;
        hold_val_r <= I_FREQ_ANALOG;
      end else if (analog_hold && tick) begin
        if (speed_up && !speed_decrease_input && hold_val_r != FREQ_MAX) begin
          hold_val_r <= hold_val_r + 16'h0001;
        end else if (speed_decrease_input && !speed_up && hold_val_r != FREQ_RST) begin
          hold_val_r <= hold_val_r - 16'h0001;
        end
      end
    end
  end

  // Writes go out only when the stored word really changes, to spare the
  // storage element's endurance
  assign nv_nxt = (I_CFG.updown_store_select == STORE_KEEP) ? hold_val_r : base_r;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_NV_HOLD_DATA <= FREQ_RST;
      O_NV_HOLD_WE   <= 1'b0;
    end else if (I_CE) begin
      if (boot_r) begin
        O_NV_HOLD_DATA <= I_NV_HOLD_DATA;
        O_NV_HOLD_WE   <= 1'b0;
      end else begin
        O_NV_HOLD_DATA <= nv_nxt;
        O_NV_HOLD_WE   <= (nv_nxt != O_NV_HOLD_DATA);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pulse counter

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      pc_prev_r             <= 1'b0;
      O_PULSE_TOTAL_MONITOR <= '0;
    end else if (I_CE) begin
      pc_prev_r <= pulse_count_input;
      if (pulse_count_clear || I_DRIVE_RESET_INPUT) begin
        O_PULSE_TOTAL_MONITOR <= '0;
      end else if (pulse_count_input && !pc_prev_r) begin
        O_PULSE_TOTAL_MONITOR <= O_PULSE_TOTAL_MONITOR + CNT_W'(1);
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_force_flip_running;
    I_CE && force_flip && O_RUN;
  endsequence
  sequence s_source_quiet;
    I_CE && !any_req;
  endsequence

  a_keypad_run_src: assert property (I_CE && keypad_force && rb_nxt == RB_FREE
    |=> O_RUN == $past(I_RUN_REQ.run_keypad) && O_FREQ_REF == $past(I_KEYPAD_FREQ_SETTING))
    else $error("keypad force did not route keypad run and frequency");

  a_config_src: assert property (I_CE && !keypad_force && !terminal_force
    |=> O_FREQ_SRC == $past(I_CFG.freq_source_select) && O_RUN_SRC == $past(I_CFG.run_source_select))
    else $error("configured sources not used with force inputs off");

  a_term_force_src: assert property (I_CE && terminal_force && !keypad_force
    |=> O_FREQ_SRC == SRC_TERMINAL && O_RUN_SRC == SRC_TERMINAL)
    else $error("terminal force did not select the terminal block");

  a_force_stop: assert property (s_force_flip_running |=> !O_RUN && rb_r == RB_LOCKED)
    else $error("run kept after a forced-source change");

  a_lock_release: assert property (rb_r == RB_LOCKED ##1 s_source_quiet ##1 s_source_quiet
    |=> rb_r == RB_FREE || $past(force_flip))
    else $error("run lock not released after all requests dropped");

  a_p_only_on: assert property (I_CE && p_pi_select && method_ok
    |=> O_P_ONLY && O_P_GAIN_VALUE >= P_GAIN_MIN && O_P_GAIN_VALUE <= P_GAIN_MAX)
    else $error("P-only mode or its gain range not applied");

  a_pi_default: assert property (I_CE && (!p_pi_select || !method_ok)
    |=> !O_P_ONLY && O_P_GAIN_VALUE == $past(I_PI_GAIN))
    else $error("PI compensation not kept outside P/PI conditions");

  a_hold_freeze: assert property (I_CE && analog_hold && ahd_prev_r && !boot_r && !drs_fall && !tick
    |=> $stable(hold_val_r) && $stable(base_r))
    else $error("held command changed without an up/down step");
  a_set_keeps_base: assert property (I_CE && analog_hold && ahd_prev_r && !boot_r && !drs_fall
    && $changed(I_CONTROL_SET_SELECT) |=> $stable(base_r)) else $error("control set change moved the held base");

  a_up_raise: assert property (I_CE && analog_hold && ahd_prev_r && !boot_r && !drs_fall && tick
    && speed_up && !speed_decrease_input && hold_val_r != FREQ_MAX |=> hold_val_r == $past(hold_val_r) + 16'h0001)
    else $error("up input failed to raise the held command by one step");

  a_pulse_clear: assert property (I_CE && pulse_count_clear |=> O_PULSE_TOTAL_MONITOR == '0)
    else $error("pulse total not cleared");

  a_pulse_count: assert property (I_CE && pulse_count_input && !pc_prev_r
    && !pulse_count_clear && !I_DRIVE_RESET_INPUT
    |=> O_PULSE_TOTAL_MONITOR == $past(O_PULSE_TOTAL_MONITOR) + CNT_W'(1))
    else $error("pulse edge not counted");
endmodule
`default_nettype wire

// ---- difl_ctrl_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module difl_ctrl_model (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [6:0] i_lvl,
  input  wire logic       i_go,
  input  wire logic [7:0] i_half,
  input  wire logic [7:0] i_num,
  output logic [7:0]      o_term,
  output logic            o_busy
);
  logic [7:0] cnt_r;
  logic [8:0] left_r;
  ////////////////////////////////////////////////////////////////
  // Pulse train on the last terminal: equal high and low phases
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r  <= 8'h00;
      left_r <= 9'h000;
    end else if (i_go) begin
      cnt_r  <= 8'h00;
      left_r <= {i_num, 1'b0};
    end else if (left_r != 9'h000) begin
      if (cnt_r == i_half - 8'h01) begin
        cnt_r  <= 8'h00;
        left_r <= left_r - 9'h001;
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
  end
  assign o_busy = left_r != 9'h000;
  // Odd phase count means high, so the line idles low between trains
  assign o_term = {left_r[0], i_lvl};
endmodule
`default_nettype wire

// ---- testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import difl_pkg::*;
  logic                      clk, rst, go, busy, drst, ce;
  logic [6:0]                lvl;
  logic [7:0]                half, num, term, o_fsrc, o_rsrc;
  logic [NUM_TERM-1:0][7:0]  fsel, resp;
  difl_cfg_t                 cfg;
  difl_run_t                 run;
  logic [FW-1:0]             fan, fkp, faux, pg, pig, nvd, o_freq, o_gain, o_nvd;
  logic [1:0]                cset;
  logic                      o_run, o_ponly, o_we;
  logic [31:0]               o_tot;
  logic [7:0]                meth [0:4];
  int                        fails, tests_run, wes;

  difl_top #(.RESP_UNIT_CYC(4), .UPDN_STEP_CYC(3), .CNT_W(32)) difl_top_i (
    .I_CORE_CLK(clk), .I_RST(rst), .I_CE(ce), .I_TERM(term), .I_INPUT_FUNCTION_SELECT(fsel),
    .I_INPUT_RESPONSE_TIME(resp), .I_CFG(cfg), .I_RUN_REQ(run), .I_FREQ_ANALOG(fan),
    .I_KEYPAD_FREQ_SETTING(fkp), .I_FREQ_AUX(faux), .I_P_ONLY_GAIN(pg), .I_PI_GAIN(pig),
    .I_DRIVE_RESET_INPUT(drst), .I_CONTROL_SET_SELECT(cset), .I_NV_HOLD_DATA(nvd),
    .O_RUN(o_run), .O_FREQ_REF(o_freq), .O_FREQ_SRC(o_fsrc), .O_RUN_SRC(o_rsrc), .O_P_ONLY(o_ponly),
    .O_P_GAIN_VALUE(o_gain), .O_PULSE_TOTAL_MONITOR(o_tot), .O_NV_HOLD_DATA(o_nvd), .O_NV_HOLD_WE(o_we));
  difl_ctrl_model difl_ctrl_model_i (
    .i_clk(clk), .i_rst(rst), .i_lvl(lvl), .i_go(go), .i_half(half), .i_num(num),
    .o_term(term), .o_busy(busy));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) begin
    if (o_we === 1'b1) begin
      wes++;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic pulses(input logic [7:0] h, input logic [7:0] n);
    half = h;
    num = n;
    go = 1'b1;
    w(1);
    go = 1'b0;
    // A stuck train is caught by the watchdog
    while (busy) w(1);
  endtask
  function automatic logic [7:0] exp_src(input logic kf, input logic tf, input logic [7:0] c);
    return kf ? SRC_KEYPAD : tf ? SRC_TERMINAL : c;
  endfunction
  function automatic logic [FW-1:0] exp_freq(input logic [7:0] s);
    return s == SRC_TERMINAL ? fan : s == SRC_KEYPAD ? fkp : faux;
  endfunction
  function automatic logic [2:0] one_hot(input logic [7:0] s);
    return s == SRC_TERMINAL ? 3'b100 : s == SRC_KEYPAD ? 3'b010 : 3'b001;
  endfunction
  function automatic logic [FW-1:0] exp_gain(input logic p);
    return !p ? pig : pg < P_GAIN_MIN ? P_GAIN_MIN : pg > P_GAIN_MAX ? P_GAIN_MAX : pg;
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    fails++;
    finish_test();
  end
  initial begin
    int i, k, nn;
    logic [1:0] m;
    logic [7:0] s;
    logic [FW-1:0] a, v, v2;
    logic p;
    i = $urandom(32'h6c82d997);
    rst = 1'b1; go = 1'b0; drst = 1'b0; lvl = 7'h00; half = 8'h01; num = 8'h00; cset = 2'h0;
    ce = 1'b1;
    fsel = {FC_PULSE_CNT, FC_PULSE_CLR, FC_SPEED_DOWN, FC_SPEED_UP, FC_ANALOG_HOLD, FC_P_PI,
            FC_TERM_FORCE, FC_KEYPAD_FORCE};
    resp = '0;
    resp[7] = 8'($urandom_range(2));
    cfg = '{8'h03, 8'h03, 8'h00, STORE_KEEP};
    run = 3'b000; fan = 16'h0000; fkp = 16'h0000; faux = 16'h0000; pg = 16'h0064; nvd = 16'h0000;
    pig = 16'($urandom);
    meth = '{8'h00, CM_SENSORLESS_VECTOR, CM_ZERO_SPEED_SENSORLESS, CM_SENSOR_VECTOR, 8'h06};
    w(12);
    rst = 1'b0;
    w(2);
    chk(o_tot, 0, "total after reset");
    // Each step flips at least one force input while running
    for (i = 0; i < 4; i++) begin
      m = 2'((i + 1) % 4);
      cfg.freq_source_select = 8'($urandom_range(3));
      cfg.run_source_select = 8'($urandom_range(3));
      fan = 16'($urandom); fkp = 16'($urandom); faux = 16'($urandom);
      run = 3'b111;
      w(4);
      chk(o_run, 1, "running before force");
      lvl[1:0] = m;
      w(10);
      chk(o_run, 0, "force change stop");
      s = exp_src(m[0], m[1], cfg.freq_source_select);
      chk(o_fsrc, s, "freq source");
      chk(o_freq, exp_freq(s), "freq ref");
      s = exp_src(m[0], m[1], cfg.run_source_select);
      chk(o_rsrc, s, "run source");
      run = 3'b000; // Release every source first
      w(2);
      run = ~one_hot(s);
      w(3);
      chk(o_run, 0, "run from other source");
      run = one_hot(s);
      w(3);
      chk(o_run, 1, "run restarts");
    end
    for (i = 0; i < 10; i++) begin
      meth[4] = 8'($urandom_range(255, 6));
      cfg.control_method_select = meth[i % 5];
      lvl[2] = (i >= 5);
      pg = (i == 6) ? 16'h0000 : (i == 8) ? 16'h03E9 : 16'($urandom_range(1100));
      p = lvl[2] && (i % 5 >= 1) && (i % 5 <= 3);
      w(8);
      chk(o_ponly, p, "p only select");
      chk(o_gain, exp_gain(p), "gain in use");
    end
    cfg.control_method_select = CM_SENSOR_VECTOR;
    fsel[2] = 8'h00;
    w(4);
    chk(o_ponly, 0, "unassigned p/pi");
    fsel[2] = FC_P_PI;
    cfg.freq_source_select = SRC_TERMINAL;
    a = 16'($urandom_range(1000, 100));
    fan = a;
    lvl[3] = 1'b1;
    w(8);
    fan = ~a;
    w(3);
    chk(o_freq, a, "held analog");
    cset = 2'h1;
    w(3);
    chk(o_freq, a, "set change keeps hold");
    lvl[4] = 1'b1;
    w(40);
    lvl[4] = 1'b0;
    w(8);
    v = o_freq;
    chk(v > a && v < a + 16'h0010, 1, "up from held");
    w(20);
    chk(o_freq, v, "steady when up off");
    lvl[5] = 1'b1;
    w(40);
    lvl[5] = 1'b0;
    w(8);
    v2 = o_freq;
    chk(v2 < v, 1, "down from held");
    chk(o_nvd, v2, "stored result");
    chk(wes > 0, 1, "store write pulse");
    cfg.updown_store_select = 8'h00;
    w(3);
    chk(o_nvd, a, "base kept without store");
    k = (int'(resp[7]) + 1) * 4;
    nn = $urandom_range(10, 3);
    pulses(8'(k + 3), 8'(nn));
    w(k + 4);
    chk(o_tot, nn, "slow pulses counted");
    pulses(8'(k / 2), 8'h05);
    w(k + 4);
    chk(o_tot, nn, "fast pulses lost");
    lvl[6] = 1'b1;
    w(8);
    chk(o_tot, 0, "count clear");
    lvl[6] = 1'b0;
    w(8);
    pulses(8'(k + 3), 8'h03);
    ce = 1'b0;
    nvd = 16'($urandom);
    drst = 1'b1;
    w(3);
    chk(o_tot, 3, "count frozen while disabled");
    ce = 1'b1;
    w(3);
    chk(o_tot, 0, "drive reset clears count");
    drst = 1'b0;
    w(4);
    chk(o_freq, nvd, "reload held value");
    finish_test();
  end
endmodule
`default_nettype wire
